/* include/ssic_params.svh */
// Register offsets, field positions and reset values of the SPI status block
`ifndef SSIC_PARAMS_SVH
`define SSIC_PARAMS_SVH

`define SSIC_ADR_IRQ      4'h6
`define SSIC_ADR_IRQEN    4'h7
`define SSIC_ADR_CR0      4'h8
`define SSIC_ADR_CR1      4'h9
`define SSIC_ADR_CR2      4'hA
`define SSIC_ADR_BR       4'hB
`define SSIC_ADR_SR       4'hC
`define SSIC_ADR_TXD      4'hD
`define SSIC_ADR_RXD      4'hE
`define SSIC_ADR_CSR      4'hF

`define SSIC_CR1_ENABLE   7
`define SSIC_CR2_MASTER   7
`define SSIC_CR2_HOLD     6
`define SSIC_CR2_LOW_BIT_FIRST     0

`define SSIC_SR_TIP       7
`define SSIC_SR_BUSY      6
`define SSIC_SR_TXE       4
`define SSIC_SR_RXF       3
`define SSIC_SR_TOE       2
`define SSIC_SR_ROE       1
`define SSIC_SR_MDF       0

`define SSIC_BR_MASK      8'h3F
`define SSIC_CS_IDLE      4'hF
`define SSIC_BITS         4'h8
`define SSIC_LAST_BIT     4'h7
`define SSIC_ZERO8        8'h00
`define SSIC_ZERO5        5'h00

`endif

/* include/ssic_pkg.sv */
// Types shared by the SPI status, interrupt and chip-select block
package ssic_pkg;

   typedef enum logic [1:0] {
      SSIC_IDLE,
      SSIC_SHIFT,
      SSIC_HOLD
   } ssic_phase_e;

   typedef struct packed {
      logic       strobe;
      logic       write;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ssic_bus_req_s;

   typedef struct packed {
      logic sck;
      logic mosi;
      logic miso;
      logic ssel_n;
   } ssic_pins_s;

   typedef struct packed {
      ssic_pins_s  s1;
      ssic_pins_s  s2;
      ssic_pins_s  s3;
      logic [7:0]  cr0;
      logic [7:0]  cr1;
      logic [7:0]  cr2;
      logic [7:0]  br;
      logic [3:0]  csr;
      logic [7:0]  txd;
      logic [7:0]  rxd;
      logic [4:0]  en;
      logic [4:0]  pend;
      logic [4:0]  fprev;
      logic        txe;
      logic        rxf;
      logic        tx_overrun_flag;
      logic        rx_overrun_flag;
      logic        mode_fault_flag;
      ssic_phase_e st;
      logic [7:0]  div;
      logic [3:0]  bits;
      logic        sck;
      logic [7:0]  sh;
      logic [7:0]  rsh;
      logic [3:0]  cs_n;
      logic        mosi_o;
      logic        miso_o;
      logic        sck_oe;
      logic        miso_oe;
      logic        ack;
      logic        done;
      logic [7:0]  rdata;
      logic        irq;
   } ssic_state_s;

endpackage

/* hdl/ssic_spi_regs.sv */
// SPI status, interrupt, data and master chip-select registers with shifter
// Function
// - Four active-low master select lines, one per chip-select register bit.
// - Writing the chip-select register stores it and resets the core.
// - Status bit 7 is high while bits are being shifted.
// - Status bit 6 is high while a framed transfer holds select low.
// - Status bit 4 flags empty transmit byte; writing it clears the flag.
// - Status bit 3 flags a valid received byte; reading it clears.
// - Status bit 1 sets when a new byte overwrites an unread one.
// - Status bit 2 flags a transmit overrun and can raise an interrupt.
// - Status bit 0 sets when slave select goes low in master mode.
// - Any control register write clears the mode fault flag.
// - Transmit byte bit 0 goes out last, or first when low-bit-first.
// - Receive byte bit 0 came in last, or first when low-bit-first.
// - Pending bits 4..0 latch the five events only while enabled.
// - Writing one to a pending bit clears it; zero leaves it.
// - Enable register holds one enable per source, bits 4..0.
// - Select goes low before the first byte and high after the last.
// - Control two bit 7 picks master mode; changing it idles the core.
`timescale 1ns/100ps
`include "ssic_params.svh"

module ssic_spi_regs
   import ssic_pkg::*;
(
   input  wire logic          clk_sys,
   input  wire logic          resetn,
   input  wire ssic_bus_req_s bus_req,
   output logic [7:0]         bus_rdata,
   output logic               bus_ack,
   input  wire ssic_pins_s    pins,
   output logic               sck_out,
   output logic               sck_oe,
   output logic               mosi_out,
   output logic               mosi_oe,
   output logic               miso_out,
   output logic               miso_oe,
   output logic [3:0]         master_select_line,
   output logic               irq
);

   ssic_state_s c;
   ssic_state_s n;
   logic        fire;
   logic        wr;
   logic        rd;
   logic        master;
   logic        enable;
   logic        low_bit_first;
   logic        sck_rise;
   logic        sck_fall;
   logic        ssn_fall;
   logic        ctrl_wr;
   logic        core_rst;
   logic        rx_done;
   logic [7:0]  rx_byte;
   logic [4:0]  flags;
   logic [7:0]  status;

   function automatic logic out_bit(input logic [7:0] s, input logic lf);
      out_bit = lf ? s[0] : s[7];
   endfunction

   function automatic logic [7:0] shift_out(input logic [7:0] s, input logic lf);
      shift_out = lf ? {1'b0, s[7:1]} : {s[6:0], 1'b0};
   endfunction

   function automatic logic [7:0] shift_in(input logic [7:0] s, input logic b,
                                           input logic lf);
      shift_in = lf ? {b, s[7:1]} : {s[6:0], b};
   endfunction

   always_comb begin
      n        = c;
      fire     = bus_req.strobe & ~c.done;
      wr       = fire & bus_req.write;
      rd       = fire & ~bus_req.write;
      master   = c.cr2[`SSIC_CR2_MASTER];
      enable   = c.cr1[`SSIC_CR1_ENABLE];
      low_bit_first     = c.cr2[`SSIC_CR2_LOW_BIT_FIRST];
      rx_done  = 1'b0;
      rx_byte  = `SSIC_ZERO8;
      // Pins pass three flops; edges are found on the second and third only
      n.s1     = pins;
      n.s2     = c.s1;
      n.s3     = c.s2;
      sck_rise = c.s2.sck & ~c.s3.sck;
      sck_fall = ~c.s2.sck & c.s3.sck;
      ssn_fall = ~c.s2.ssel_n & c.s3.ssel_n;
      ctrl_wr  = wr & (bus_req.addr[3:0] == `SSIC_ADR_CR0 |
                       bus_req.addr[3:0] == `SSIC_ADR_CR1 |
                       bus_req.addr[3:0] == `SSIC_ADR_CR2);
      core_rst = ctrl_wr | (wr & (bus_req.addr[3:0] == `SSIC_ADR_BR |
                                  bus_req.addr[3:0] == `SSIC_ADR_CSR));
      n.ack    = fire;
      n.done   = bus_req.strobe & (c.done | fire);

      status[`SSIC_SR_TIP]  = master ? (c.st == SSIC_SHIFT)
                                     : (~c.s2.ssel_n & (c.bits != 4'h0));
      status[`SSIC_SR_BUSY] = master ? (c.st != SSIC_IDLE) : ~c.s2.ssel_n;
      status[5]             = 1'b0;
      status[`SSIC_SR_TXE]  = c.txe;
      status[`SSIC_SR_RXF]  = c.rxf;
      status[`SSIC_SR_TOE]  = c.tx_overrun_flag;
      status[`SSIC_SR_ROE]  = c.rx_overrun_flag;
      status[`SSIC_SR_MDF]  = c.mode_fault_flag;

      if (rd) begin
         case (bus_req.addr[3:0])
            `SSIC_ADR_IRQ:   n.rdata = {3'h0, c.pend};
            `SSIC_ADR_IRQEN: n.rdata = {3'h0, c.en};
            `SSIC_ADR_CR0:   n.rdata = c.cr0;
            `SSIC_ADR_CR1:   n.rdata = c.cr1;
            `SSIC_ADR_CR2:   n.rdata = c.cr2;
            `SSIC_ADR_BR:    n.rdata = c.br;
            `SSIC_ADR_SR:    n.rdata = status;
            `SSIC_ADR_RXD:   n.rdata = c.rxd;
            `SSIC_ADR_CSR:   n.rdata = {4'h0, c.csr};
            default:         n.rdata = `SSIC_ZERO8;
         endcase
         if (bus_req.addr[3:0] == `SSIC_ADR_RXD) begin
            n.rxf = 1'b0;
         end
         // Overrun flags clear on a status read here, and also on a core reset
         if (bus_req.addr[3:0] == `SSIC_ADR_SR) begin
            n.tx_overrun_flag = 1'b0;
            n.rx_overrun_flag = 1'b0;
         end
      end

      if (wr) begin
         case (bus_req.addr[3:0])
            `SSIC_ADR_CR0:   n.cr0 = bus_req.wdata;
            `SSIC_ADR_CR1:   n.cr1 = bus_req.wdata;
            `SSIC_ADR_CR2:   n.cr2 = bus_req.wdata;
            `SSIC_ADR_BR:    n.br  = bus_req.wdata & `SSIC_BR_MASK;
            // Low nibble drives the select lines
            `SSIC_ADR_CSR:   n.csr = bus_req.wdata[3:0];
            `SSIC_ADR_IRQEN: n.en  = bus_req.wdata[4:0];
            `SSIC_ADR_IRQ:   n.pend = c.pend & ~bus_req.wdata[4:0];
            `SSIC_ADR_TXD: begin
               n.txd = bus_req.wdata;
               // Overwriting an unsent byte is a transmit overrun
               if (!c.txe) begin
                  n.tx_overrun_flag = 1'b1;
               end
               n.txe = 1'b0;
            end
            default: ;
         endcase
      end
      if (ctrl_wr) begin
         n.mode_fault_flag = 1'b0;
      end

      if (!enable) begin
         n.st   = SSIC_IDLE;
         n.cs_n = `SSIC_CS_IDLE;
         n.sck  = 1'b0;
         n.bits = 4'h0;
      end else if (master) begin
         case (c.st)
            SSIC_IDLE: begin
               n.cs_n = `SSIC_CS_IDLE;
               n.sck  = 1'b0;
               if (!c.txe) begin
                  // Select drops with the first byte
                  n.cs_n = c.csr;
                  n.sh   = c.txd;
                  n.txe  = 1'b1;
                  n.st   = SSIC_SHIFT;
                  n.div  = `SSIC_ZERO8;
                  n.bits = 4'h0;
               end
            end
            SSIC_SHIFT: begin
               // Each half period lasts divider plus one system clocks
               if (c.div == c.br) begin
                  n.div = `SSIC_ZERO8;
                  n.sck = ~c.sck;
                  if (!c.sck) begin
                     n.bits = c.bits + 4'h1;
                  end else begin
                     // Sampled late in the high phase, past the pin synchroniser
                     n.rsh = shift_in(c.rsh, c.s2.miso, low_bit_first);
                  end
                  if (c.sck & (c.bits == `SSIC_BITS)) begin
                     rx_done = 1'b1;
                     rx_byte = n.rsh;
                     n.bits  = 4'h0;
                     if (!c.txe) begin
                        n.sh  = c.txd;
                        n.txe = 1'b1;
                     end else if (c.cr2[`SSIC_CR2_HOLD]) begin
                        n.st = SSIC_HOLD;
                     end else begin
                        // Select rises after the last byte
                        n.st   = SSIC_IDLE;
                        n.cs_n = `SSIC_CS_IDLE;
                     end
                  end else if (c.sck) begin
                     // Bit order out of transmit byte
                     n.sh = shift_out(c.sh, low_bit_first);
                  end
               end else begin
                  n.div = c.div + 8'h01;
               end
            end
            SSIC_HOLD: begin
               if (!c.txe) begin
                  n.sh   = c.txd;
                  n.txe  = 1'b1;
                  n.st   = SSIC_SHIFT;
                  n.div  = `SSIC_ZERO8;
               end else if (!c.cr2[`SSIC_CR2_HOLD]) begin
                  n.st   = SSIC_IDLE;
                  n.cs_n = `SSIC_CS_IDLE;
               end
            end
            default: n.st = SSIC_IDLE;
         endcase
      end else begin
         // Slave: the byte must already sit in the holding register at load
         n.st   = c.s2.ssel_n ? SSIC_IDLE : SSIC_SHIFT;
         n.cs_n = `SSIC_CS_IDLE;
         if (c.s2.ssel_n) begin
            n.bits = 4'h0;
         end else if (ssn_fall | (sck_fall & c.bits == `SSIC_BITS)) begin
            n.bits = 4'h0;
            if (!c.txe) begin
               n.sh  = c.txd;
               n.txe = 1'b1;
            end
         end else if (sck_rise) begin
            n.rsh  = shift_in(c.rsh, c.s2.mosi, low_bit_first);
            n.bits = c.bits + 4'h1;
            if (c.bits == `SSIC_LAST_BIT) begin
               rx_done = 1'b1;
               rx_byte = n.rsh;
            end
         end else if (sck_fall) begin
            // Bit order out of transmit byte
            n.sh = shift_out(c.sh, low_bit_first);
         end
      end

      // A write that meets a load leaves the new byte held
      n.txe = n.txe & ~(wr & (bus_req.addr[3:0] == `SSIC_ADR_TXD));
      if (rx_done) begin
         if (c.rxf & ~(rd & bus_req.addr[3:0] == `SSIC_ADR_RXD)) begin
            n.rx_overrun_flag = 1'b1;
         end
         // Set wins over the read clear
         n.rxd = rx_byte;
         n.rxf = 1'b1;
      end

      // Any control, baud rate or select register write forces idle
      if (core_rst) begin
         n.st   = SSIC_IDLE;
         n.cs_n = `SSIC_CS_IDLE;
         n.sck  = 1'b0;
         n.bits = 4'h0;
         n.div  = `SSIC_ZERO8;
         n.txe  = 1'b1;
         n.rxf  = 1'b0;
         n.tx_overrun_flag  = 1'b0;
         n.rx_overrun_flag  = 1'b0;
      end

      if (master & ~c.s2.ssel_n) begin
         n.mode_fault_flag = 1'b1;
      end

      // Rising flags latch while enabled; set wins over the clear
      flags   = {n.txe, n.rxf, n.tx_overrun_flag, n.rx_overrun_flag, n.mode_fault_flag};
      n.fprev = flags;
      n.pend  = n.pend | (flags & ~c.fprev & c.en);
      // Any pending bit raises the request
      n.irq   = |n.pend;

      n.mosi_o  = out_bit(n.sh, n.cr2[`SSIC_CR2_LOW_BIT_FIRST]);
      n.miso_o  = n.mosi_o;
      n.sck_oe  = n.cr1[`SSIC_CR1_ENABLE] & n.cr2[`SSIC_CR2_MASTER];
      n.miso_oe = n.cr1[`SSIC_CR1_ENABLE] & ~n.cr2[`SSIC_CR2_MASTER] & ~c.s2.ssel_n;
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         c           <= '0;
         c.s1.ssel_n <= 1'b1;
         c.s2.ssel_n <= 1'b1;
         c.s3.ssel_n <= 1'b1;
         c.txe       <= 1'b1;
         c.fprev     <= `SSIC_ZERO5;
         c.cs_n      <= `SSIC_CS_IDLE;
         c.st        <= SSIC_IDLE;
      end else begin
         c <= n;
      end
   end

   assign bus_rdata          = c.rdata;
   assign bus_ack            = c.ack;
   assign sck_out            = c.sck;
   assign sck_oe             = c.sck_oe;
   assign mosi_out           = c.mosi_o;
   assign mosi_oe            = c.sck_oe;
   assign miso_out           = c.miso_o;
   assign miso_oe            = c.miso_oe;
   assign master_select_line = c.cs_n;
   assign irq                = c.irq;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);

   a_csr_write_reset: assert property (
      (wr && bus_req.addr[3:0] == `SSIC_ADR_CSR) |=>
         (c.st == SSIC_IDLE && c.csr == $past(bus_req.wdata[3:0]) && c.txe))
      else $error("select write did not store and reset");
   a_busy_framed: assert property (
      (master && enable && c.st != SSIC_IDLE) |-> c.cs_n != `SSIC_CS_IDLE || $past(core_rst))
      else $error("transfer running with select high");
   a_tx_write_clear: assert property (
      (wr && bus_req.addr[3:0] == `SSIC_ADR_TXD) |=> !c.txe)
      else $error("transmit write did not clear empty flag");
   a_rx_read_clear: assert property (
      (rd && bus_req.addr[3:0] == `SSIC_ADR_RXD && !rx_done && !core_rst) |=> !c.rxf)
      else $error("receive read did not clear full flag");
   a_rx_overrun: assert property (
      (rx_done && c.rxf && !rd && !core_rst) |=> (c.rx_overrun_flag && c.rxf))
      else $error("lost byte not flagged");
   a_mode_fault: assert property (
      (master && !c.s2.ssel_n) |=> c.mode_fault_flag [*2] or ##1 $past(ctrl_wr, 1) ##0 1'b1)
      else $error("mode fault not set");
   a_mdf_cleared: assert property (
      (ctrl_wr && !(master && !c.s2.ssel_n)) |=> !c.mode_fault_flag)
      else $error("control write did not clear mode fault");
   a_pend_w1c: assert property (
      (wr && bus_req.addr[3:0] == `SSIC_ADR_IRQ) |=>
         ((c.pend & ~$past(c.pend) & ~$past(c.en)) == `SSIC_ZERO5) &&
         ((c.pend & $past(bus_req.wdata[4:0]) & ~$past(flags & ~c.fprev)) ==
          `SSIC_ZERO5))
      else $error("pending bit not cleared by one");
   a_pend_masked: assert property (
      ((c.pend & ~$past(c.pend) & ~$past(c.en)) == `SSIC_ZERO5))
      else $error("disabled source became pending");
   a_irq_level: assert property (irq == (|c.pend))
      else $error("interrupt output disagrees with pending");
   a_ack_pulse: assert property (
      bus_ack |=> !bus_ack)
      else $error("acknowledge longer than one cycle");

   c_master_byte: cover property (master && rx_done);
   c_slave_byte:  cover property (!master && rx_done);
   c_overrun:     cover property ($rose(c.rx_overrun_flag));
   c_irq_raised:  cover property ($rose(irq));

endmodule

/* testbench/ssic_spi_slave_model.sv */
// Behavioural external SPI slave, mode 0, seen by the master side of the block
`timescale 1ns/100ps

module ssic_spi_slave_model (
   input  wire logic       sck,
   input  wire logic       mosi,
   input  wire logic       sel_n,
   input  wire logic [7:0] reply,
   output logic            miso,
   output logic [7:0]      got
);
   logic [7:0] sh;

   initial begin
      miso = 1'b0;
      got  = 8'h00;
      sh   = 8'h00;
   end

   always @(negedge sel_n) begin
      sh   = reply;
      miso = reply[7];
   end

   // Capture on rise, first bit lands in bit 7 after eight
   always @(posedge sck) begin
      if (!sel_n) begin
         got = {got[6:0], mosi};
      end
   end

   // Shift out on fall, MSB first
   always @(negedge sck) begin
      if (!sel_n) begin
         sh   = {sh[6:0], 1'b0};
         miso = sh[7];
      end
   end

   // Released line carries no valid level, so show the inverse of the last bit
   always @(posedge sel_n) begin
      miso = ~miso;
   end
endmodule

/* testbench/ssic_spi_regs_tb.sv */
// Self-checking testbench for the SPI status, interrupt and chip-select block
`timescale 1ns/100ps

module ssic_spi_regs_tb
   import ssic_pkg::*;
   ;
   logic          clk_sys;
   logic          resetn;
   ssic_bus_req_s bus_req;
   logic [7:0]    bus_rdata;
   logic          bus_ack;
   ssic_pins_s    pins;
   logic          sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
   logic [3:0]    master_select_line;
   logic          irq;
   logic          tb_sck, tb_mosi, tb_ssel_n, slv_miso;
   logic [7:0]    reply, got;
   int            errors, compares;

   // Wire level resolved from whoever enables its driver
   assign pins = '{sck_oe ? sck_out : tb_sck, mosi_oe ? mosi_out : tb_mosi,
                   miso_oe ? miso_out : slv_miso, tb_ssel_n};

   ssic_spi_regs uut (
      .clk_sys            (clk_sys),
      .resetn             (resetn),
      .bus_req            (bus_req),
      .bus_rdata          (bus_rdata),
      .bus_ack            (bus_ack),
      .pins               (pins),
      .sck_out            (sck_out),
      .sck_oe             (sck_oe),
      .mosi_out           (mosi_out),
      .mosi_oe            (mosi_oe),
      .miso_out           (miso_out),
      .miso_oe            (miso_oe),
      .master_select_line (master_select_line),
      .irq                (irq)
   );

   ssic_spi_slave_model slave (
      .sck   (pins.sck),
      .mosi  (pins.mosi),
      .sel_n (master_select_line[0]),
      .reply (reply),
      .miso  (slv_miso),
      .got   (got)
   );

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string m);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH t=%0t %s seen %h expected %h", $time, m, seen, exp);
      end
   endtask

   // Request held until the edge that samples the acknowledge
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
      int n;
      @(posedge clk_sys);
      bus_req <= '{1'b1, wr, a, d};
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (bus_ack !== 1'b1 && n < 10);
      if (bus_ack !== 1'b1) chk(8'h00, 8'h01, "no acknowledge");
      q = bus_rdata;
      bus_req.strobe <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      xfer(1'b1, a, d, q);
   endtask

   task automatic rc(input logic [7:0] a, input logic [7:0] exp, input string m,
                     input logic [7:0] mk = 8'hFF);
      logic [7:0] q;
      xfer(1'b0, a, 8'h00, q);
      chk(q & mk, exp, m);
   endtask

   // Bounded wait for select to drop and rise again
   task automatic frame();
      int n;
      n = 0;
      while (master_select_line[0] !== 1'b0 && n < 40) begin
         @(posedge clk_sys);
         n++;
      end
      n = 0;
      while (master_select_line[0] !== 1'b1 && n < 600) begin
         @(posedge clk_sys);
         n++;
      end
      repeat (4) @(posedge clk_sys);
   endtask

   // Each of these writes also resets the core, so data goes last
   task automatic mcfg(input logic [7:0] cr2);
      wr(8'h0B, 8'h01);
      wr(8'h0F, 8'h0E);
      wr(8'h0A, cr2);
      wr(8'h09, 8'h80);
   endtask

   task automatic t_reset();
      rc(8'h0C, 8'h10, "status after reset", 8'h1F);
      rc(8'h0F, 8'h00, "select reg after reset");
      rc(8'h06, 8'h00, "pending after reset", 8'h1F);
      chk({4'h0, master_select_line}, 8'h0F, "select lines idle");
      rc(8'h02, 8'h00, "unmapped read");
      rc(8'h0D, 8'h00, "transmit reads zero");
      wr(8'h07, 8'hFF);
      rc(8'h07, 8'h1F, "enable write read", 8'h1F);
      wr(8'h07, 8'h00);
      $display("test reset done");
   endtask

   task automatic t_master();
      mcfg(8'h80);
      wr(8'h07, 8'h08);
      reply = 8'hC5;
      wr(8'h0D, 8'hA5);
      repeat (6) @(posedge clk_sys);
      chk({4'h0, master_select_line}, 8'h0E, "select line 0 low");
      rc(8'h0C, 8'hC0, "shifting and busy", 8'hC0);
      frame();
      chk(got, 8'hA5, "byte sent msb first");
      rc(8'h0C, 8'h18, "status after frame", 8'hD8);
      rc(8'h06, 8'h08, "only enabled event latched", 8'h1F);
      chk({7'h00, irq}, 8'h01, "irq raised");
      rc(8'h0E, 8'hC5, "byte received msb first");
      rc(8'h0C, 8'h00, "rx full cleared by read", 8'h08);
      wr(8'h06, 8'h00);
      rc(8'h06, 8'h08, "zero write keeps pending", 8'h1F);
      wr(8'h06, 8'h08);
      rc(8'h06, 8'h00, "one write clears pending", 8'h1F);
      chk({7'h00, irq}, 8'h00, "irq dropped");
      $display("test master done");
   endtask

   task automatic t_lsb();
      mcfg(8'h81);
      reply = 8'hC5;
      wr(8'h0D, 8'h01);
      frame();
      chk(got, 8'h80, "bit 0 sent first");
      rc(8'h0E, 8'hA3, "first bit stored in bit 0");
      $display("test lsb first done");
   endtask

   task automatic t_overrun();
      mcfg(8'h80);
      wr(8'h07, 8'h06);
      wr(8'h06, 8'h1F);
      wr(8'h0D, 8'h11);
      wr(8'h0D, 8'h22);
      wr(8'h0D, 8'h33);
      frame();
      rc(8'h0C, 8'h06, "both overruns set", 8'h06);
      rc(8'h0C, 8'h00, "overruns cleared", 8'h06);
      rc(8'h06, 8'h06, "overrun events latched", 8'h1F);
      chk({7'h00, irq}, 8'h01, "irq on overrun");
      wr(8'h06, 8'h1F);
      rc(8'h0E, 8'h00, "drain receive", 8'h00);
      $display("test overrun done");
   endtask

   task automatic t_fault();
      mcfg(8'h80);
      wr(8'h07, 8'h01);
      @(posedge clk_sys);
      tb_ssel_n <= 1'b0;
      repeat (4) @(posedge clk_sys);
      tb_ssel_n <= 1'b1;
      rc(8'h0C, 8'h01, "mode fault set", 8'h01);
      rc(8'h06, 8'h01, "mode fault latched", 8'h1F);
      wr(8'h08, 8'h00);
      rc(8'h0C, 8'h00, "control write clears fault", 8'h01);
      wr(8'h06, 8'h1F);
      wr(8'h07, 8'h00);
      $display("test mode fault done");
   endtask

   task automatic t_csreset();
      mcfg(8'h80);
      wr(8'h0D, 8'h5A);
      repeat (6) @(posedge clk_sys);
      wr(8'h0F, 8'h0D);
      repeat (2) @(posedge clk_sys);
      chk({4'h0, master_select_line}, 8'h0F, "select released by reset");
      rc(8'h0C, 8'h10, "core idle after select write", 8'hD0);
      rc(8'h0F, 8'h0D, "select value stored", 8'h0F);
      $display("test select reset done");
   endtask

   // External master at the link rate: 8 system clocks per serial clock
   task automatic t_slave();
      logic [15:0] q;
      logic [15:0] d;
      d = 16'h5A24;
      wr(8'h0A, 8'h00);
      wr(8'h09, 8'h80);
      // Transmit byte written while empty, well before the frame
      wr(8'h0D, 8'h96);
      @(posedge clk_sys);
      tb_ssel_n <= 1'b0;
      repeat (8) @(posedge clk_sys);
      // Second byte is the dummy that the loaded reply rides on
      for (int i = 15; i >= 0; i--) begin
         tb_mosi <= d[i];
         repeat (4) @(posedge clk_sys);
         q[i] = miso_out;
         tb_sck <= 1'b1;
         if (i == 8) begin
            // Reply written while empty, before the last fall of byte one
            wr(8'h0D, 8'h3C);
            @(posedge clk_sys);
         end else begin
            repeat (4) @(posedge clk_sys);
         end
         tb_sck <= 1'b0;
      end
      repeat (8) @(posedge clk_sys);
      tb_ssel_n <= 1'b1;
      chk(q[15:8], 8'h96, "slave byte out");
      chk(q[7:0], 8'h3C, "slave reply on dummy byte");
      rc(8'h0C, 8'h02, "slave unread byte overrun", 8'h02);
      rc(8'h0E, 8'h24, "slave byte in");
      $display("test slave done");
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial begin
      #2000000;
      errors++;
      $display("watchdog expired");
      end_of_test();
   end

   initial begin
      errors = 0;
      compares = 0;
      bus_req = '0;
      tb_sck = 1'b0;
      tb_mosi = 1'b0;
      tb_ssel_n = 1'b1;
      reply = 8'h00;
      resetn = 1'b0;
      repeat (6) @(posedge clk_sys);
      resetn <= 1'b1;
      t_reset();
      t_master();
      t_lsb();
      t_overrun();
      t_fault();
      t_csreset();
      t_slave();
      end_of_test();
   end
endmodule
